// File: tb/tcc_cpu.sv
`timescale 1ns/10ps
module tcc_cpu (
    input  wire logic        mclk,
    input  wire logic [31:0] reg_rdata,
    output logic      [3:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    // Read data live only in the cycle after the strobe, so it is taken just past that edge.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// File: tb/timer_compare_command_bench.sv
`timescale 1ns/10ps
module timer_compare_command_bench import tcc_pkg::*;;
    logic        mclk;
    logic        sys_rst;
    logic        slot_strobe;
    logic        virt_valid;
    logic        virt_zero;
    logic        dflt_zero;
    logic [15:0] virt_count;
    logic [15:0] dflt_count;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  pin_out;
    logic        cmd_flag;
    logic        next_def;
    logic        step_mode;
    logic        slot_done;
    logic [7:0]  m_pins;
    logic        m_flag;
    logic [31:0] c;
    logic [31:0] d;
    logic [15:0] vc;
    logic [15:0] dc;
    logic [2:0]  r;
    int          n_fail;
    int          n_checks;
    tcc_cpu u_tcc_cpu (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_wr(reg_wr), .reg_rd(reg_rd));
    tcc_top u_tcc_top (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_strobe(slot_strobe),
                       .virt_valid(virt_valid), .virt_count(virt_count), .virt_zero(virt_zero),
                       .dflt_count(dflt_count), .dflt_zero(dflt_zero), .pin_out(pin_out), .cmd_flag(cmd_flag),
                       .next_def(next_def), .step_mode(step_mode), .slot_done(slot_done));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic summarize;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Timer inputs are held until the slot completes so the sampled value cannot shift under it.
    task automatic slot;
        logic [15:0] t;
        logic        z;
        logic        ok;
        logic        m;
        int          k;
        // The caller's timer inputs land at the edge before this one, so they are read only now.
        @(posedge mclk);
        slot_strobe <= 1'b1;
        t  = virt_valid ? virt_count : dflt_count;
        z  = virt_valid ? virt_zero : dflt_zero;
        ok = (c[24:23] == 2'h0);
        m  = (t == c[15:0]);
        @(posedge mclk);
        slot_strobe <= 1'b0;
        for (k = 0; k < 3 && slot_done !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        if (slot_done !== 1'b1) begin
            n_fail++;
            summarize();
        end
        chk(32'(k), 32'h1);
        if (ok) begin
            m_flag = m_flag | (m & c[17]) | (z & c[26]);
            if (c[27] && m) m_pins[c[20:18]] = c[21];
            else if (c[27] && z && c[25]) m_pins[c[20:18]] = ~c[21];
            chk(32'({step_mode, next_def}), 32'({c[22], c[16]}));
        end else begin
            chk(32'({step_mode, next_def}), 32'({1'b0, c[16]}));
        end
        chk(32'(pin_out), 32'(m_pins));
        chk(32'(cmd_flag), 32'(m_flag));
        u_tcc_cpu.rd(ADDR_TIMER, d);
        chk(d, 32'(t));
        u_tcc_cpu.rd(ADDR_STATUS, d);
        chk(d, 32'({ok & c[22], c[16], z, m_flag}));
    endtask
    initial begin
        sys_rst     = 1'b1;
        slot_strobe = 1'b0;
        virt_valid  = 1'b0;
        virt_zero   = 1'b0;
        dflt_zero   = 1'b0;
        virt_count  = 16'h0;
        dflt_count  = 16'h0;
        n_fail      = 0;
        n_checks    = 0;
        m_pins      = 8'h0;
        m_flag      = 1'b0;
        void'($urandom(20846));
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 90; i++) begin
            c  = $urandom;
            vc = 16'($urandom);
            dc = 16'($urandom);
            r  = 3'($urandom);
            if (i % 2 == 1) c[15:0] = r[0] ? vc : dc;
            if (i % 7 != 3) c[24:23] = 2'h0;
            u_tcc_cpu.wr(ADDR_CMD, c);
            u_tcc_cpu.rd(ADDR_CMD, d);
            chk(d, c);
            @(posedge mclk);
            virt_valid <= r[0];
            virt_count <= vc;
            dflt_count <= dc;
            virt_zero  <= r[1];
            dflt_zero  <= r[2];
            slot();
            u_tcc_cpu.rd(ADDR_PINS, d);
            chk(d, 32'(m_pins));
            if (i % 5 == 0) begin
                u_tcc_cpu.wr(ADDR_STATUS, 32'h1);
                m_flag = 1'b0;
                u_tcc_cpu.rd(ADDR_STATUS, d);
                chk(32'(d[0]), 32'h0);
            end
        end
        u_tcc_cpu.wr(4'hE, 32'hFFFF_FFFF);
        u_tcc_cpu.rd(ADDR_CMD, d);
        chk(d, c);
        u_tcc_cpu.rd(4'hF, d);
        chk(d, 32'h0);
        summarize();
    end
endmodule

// File: verilog/tcc_cmd_if.sv
`timescale 1ns/10ps
interface tcc_cmd_if;
    logic [31:0] cmd;
    logic [15:0] timer;
    logic        timer_zero;
    logic        match;
    logic        zero_hit;
    logic        valid;
    logic        step;
    logic        next_is_def;
    modport decoder (input cmd, input timer, input timer_zero,
                     output match, output zero_hit, output valid, output step, output next_is_def);
    modport user    (output cmd, output timer, output timer_zero,
                     input match, input zero_hit, input valid, input step, input next_is_def);
endinterface

// File: verilog/tcc_decode.sv
`timescale 1ns/10ps
module tcc_decode
    import tcc_pkg::*;
(
    tcc_cmd_if.decoder bus
);
    // Bits 28..31 are never looked at, so reserved content is harmless.
    always_comb begin
        bus.valid       = ~bus.cmd[MBZ0_BIT] & ~bus.cmd[MBZ1_BIT];
        bus.match       = bus.valid && (bus.timer == bus.cmd[CMP_LSB +: CMP_W]);
        bus.zero_hit    = bus.valid && bus.timer_zero;
        bus.step        = bus.valid && bus.cmd[STEP_BIT];
        bus.next_is_def = bus.cmd[NXT_DEF_BIT];
    end
endmodule

// File: verilog/tcc_pkg.sv
package tcc_pkg;

    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int CMP_LSB      = 0;
    localparam int CMP_W        = 16;
    localparam int NXT_DEF_BIT  = 16;
    localparam int IRQ_CMP_BIT  = 17;
    localparam int PIN_LSB      = 18;
    localparam int PIN_W        = 3;
    localparam int ACT_SET_BIT  = 21;
    localparam int STEP_BIT     = 22;
    localparam int MBZ0_BIT     = 23;
    localparam int MBZ1_BIT     = 24;
    localparam int RST_ACT_BIT  = 25;
    localparam int IRQ_RST_BIT  = 26;
    localparam int PIN_EN_BIT   = 27;
    localparam int NUM_PINS     = 8;

    // ------------------------------------------------------------
    // Register map of the plain software port
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CMD    = 4'h0;
    localparam logic [3:0] ADDR_TIMER  = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_PINS   = 4'h3;
    localparam logic [31:0] CMD_RESET  = 32'h0000_0000;

    // Slot sequencing states.
    typedef enum logic [1:0] {
        TCC_IDLE  = 2'b00,
        TCC_FETCH = 2'b01,
        TCC_EXEC  = 2'b10
    } tcc_state_type;

endpackage

// File: verilog/tcc_top.sv
`timescale 1ns/10ps
// Function
// - Compare low sixteen bits with referred timer.
// - Referred timer: last virtual, else default.
// - Bit 16 flags next entry as definition.
// - Bit 17 raises flag on compare match.
// - Bits 20..18 select pin index.
// - Bit 21 picks set or clear on match.
// - Bit 22 enables step mode for followers.
// - Bit 25 does opposite action on reset.
// - Bit 26 raises flag on timer reset.
// - Bit 27 gates all pin actions.
// - Each command takes exactly one slot.
module tcc_top
    import tcc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        slot_strobe,
    input  wire logic        virt_valid,
    input  wire logic [15:0] virt_count,
    input  wire logic        virt_zero,
    input  wire logic [15:0] dflt_count,
    input  wire logic        dflt_zero,
    output logic [NUM_PINS-1:0] pin_out,
    output logic             cmd_flag,
    output logic             next_def,
    output logic             step_mode,
    output logic             slot_done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tcc_state_type      state;
        logic [31:0]        cmd;
        logic [15:0]        timer;
        logic               tzero;
        logic [NUM_PINS-1:0] pins;
        logic               flag;
        logic               next_def;
        logic               step;
        logic               done;
        logic [31:0]        rdata;
    } tcc_regs_type;

    tcc_regs_type r;
    tcc_regs_type next_r;

    tcc_cmd_if dec_bus ();

    assign dec_bus.cmd        = r.cmd;
    assign dec_bus.timer      = r.timer;
    assign dec_bus.timer_zero = r.tzero;

    tcc_decode u_decode (
        .bus (dec_bus.decoder)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [PIN_W-1:0] sel;
        sel    = r.cmd[PIN_LSB +: PIN_W];
        next_r = r;
        next_r.done  = 1'b0;
        next_r.rdata = 32'h0000_0000;
        // Hardware set beats software clear of the flag below.
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CMD: begin
                    next_r.cmd = reg_wdata;
                end
                ADDR_STATUS: begin
                    if (reg_wdata[0]) begin
                        next_r.flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        case (r.state)
            TCC_IDLE: begin
                if (slot_strobe) begin
                    // Sample the referred timer at the slot start.
                    next_r.timer = virt_valid ? virt_count : dflt_count;
                    next_r.tzero = virt_valid ? virt_zero : dflt_zero;
                    next_r.state = TCC_EXEC;
                end
            end
            TCC_EXEC: begin
                // One slot: evaluate, act and release in this cycle.
                if (dec_bus.match && r.cmd[IRQ_CMP_BIT]) begin
                    next_r.flag = 1'b1;
                end
                if (dec_bus.zero_hit && r.cmd[IRQ_RST_BIT]) begin
                    next_r.flag = 1'b1;
                end
                if (dec_bus.valid && r.cmd[PIN_EN_BIT]) begin
                    if (dec_bus.zero_hit && r.cmd[RST_ACT_BIT]) begin
                        next_r.pins[sel] = ~r.cmd[ACT_SET_BIT];
                    end
                    if (dec_bus.match) begin
                        next_r.pins[sel] = r.cmd[ACT_SET_BIT];
                    end
                end
                next_r.next_def = dec_bus.next_is_def;
                next_r.step     = dec_bus.step;
                next_r.done     = 1'b1;
                next_r.state    = TCC_IDLE;
            end
            default: begin
                next_r.state = TCC_IDLE;
            end
        endcase
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CMD: begin
                    next_r.rdata = r.cmd;
                end
                ADDR_TIMER: begin
                    next_r.rdata = {16'h0000, r.timer};
                end
                ADDR_STATUS: begin
                    next_r.rdata = {28'h0000000, r.step, r.next_def, r.tzero, r.flag};
                end
                ADDR_PINS: begin
                    next_r.rdata = {24'h000000, r.pins};
                end
                default: begin
                    next_r.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r       <= '0;
            r.state <= TCC_IDLE;
            r.cmd   <= CMD_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign pin_out   = r.pins;
    assign cmd_flag  = r.flag;
    assign next_def  = r.next_def;
    assign step_mode = r.step;
    assign slot_done = r.done;

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Pins that the command in execution must leave untouched.
    logic [NUM_PINS-1:0] pin_keep;
    logic                sw_clear;
    logic [CMP_W-1:0]    ref_now;

    assign pin_keep = ~(NUM_PINS'(1) << r.cmd[PIN_LSB +: PIN_W]);
    assign sw_clear = reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[0];
    assign ref_now  = virt_valid ? virt_count : dflt_count;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    slot_one_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_IDLE && slot_strobe) |=> ##1 slot_done)
        else $error("slot did not finish in one slot");
    cmp_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && dec_bus.match && r.cmd[IRQ_CMP_BIT]) |=> cmd_flag)
        else $error("compare flag missing");
    rst_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && dec_bus.zero_hit && r.cmd[IRQ_RST_BIT]) |=> cmd_flag)
        else $error("reset flag missing");
    cmp_pin_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && dec_bus.match && r.cmd[PIN_EN_BIT] && !reg_wr)
        |=> pin_out[$past(r.cmd[PIN_LSB +: PIN_W])] == $past(r.cmd[ACT_SET_BIT]))
        else $error("compare pin action wrong");
    rst_pin_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && dec_bus.zero_hit && !dec_bus.match
         && r.cmd[PIN_EN_BIT] && r.cmd[RST_ACT_BIT])
        |=> pin_out[$past(r.cmd[PIN_LSB +: PIN_W])] != $past(r.cmd[ACT_SET_BIT]))
        else $error("reset pin action wrong");
    pin_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && !r.cmd[PIN_EN_BIT]) |=> $stable(pin_out))
        else $error("pins moved while disabled");
    cmp_value_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_IDLE && slot_strobe && !reg_wr)
        |=> dec_bus.match == (!r.cmd[MBZ0_BIT] && !r.cmd[MBZ1_BIT] && r.cmd[CMP_LSB +: CMP_W] == $past(ref_now)))
        else $error("match does not follow the compare value");
    ref_timer_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_IDLE && slot_strobe)
        |=> r.timer == ($past(virt_valid) ? $past(virt_count) : $past(dflt_count)))
        else $error("wrong referred timer");
    invalid_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && (r.cmd[MBZ0_BIT] || r.cmd[MBZ1_BIT])) |=> $stable(pin_out))
        else $error("invalid command acted");
    def_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC) |=> next_def == $past(r.cmd[NXT_DEF_BIT]))
        else $error("next definition flag wrong");

    // ------------------------------------------------------------
    // Checks: slot sequencing
    // ------------------------------------------------------------
    slot_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
        slot_done |=> !slot_done)
        else $error("slot done held too long");

    slot_back_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC) |=> (r.state == TCC_IDLE))
        else $error("slot did not return to idle");

    slot_early_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_IDLE) |=> !slot_done)
        else $error("slot done without a slot");

    // ------------------------------------------------------------
    // Checks: referred timer
    // ------------------------------------------------------------
    timer_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(r.state == TCC_IDLE && slot_strobe) |=> $stable(r.timer))
        else $error("sampled timer moved outside a slot start");

    tzero_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(r.state == TCC_IDLE && slot_strobe) |=> $stable(r.tzero))
        else $error("sampled zero moved outside a slot start");

    dflt_pick_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_IDLE && slot_strobe && !virt_valid) |=> r.tzero == $past(dflt_zero))
        else $error("default zero not taken");

    virt_pick_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_IDLE && slot_strobe && virt_valid) |=> r.tzero == $past(virt_zero))
        else $error("virtual zero not taken");

    // ------------------------------------------------------------
    // Checks: interrupt flag
    // ------------------------------------------------------------
    flag_source_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!cmd_flag && r.state != TCC_EXEC) |=> !cmd_flag)
        else $error("flag rose outside a slot");

    flag_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmd_flag && !sw_clear) |=> cmd_flag)
        else $error("flag dropped without a clear");

    flag_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (sw_clear && r.state != TCC_EXEC) |=> !cmd_flag)
        else $error("flag clear ignored");

    flag_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && !cmd_flag && (r.cmd[MBZ0_BIT] || r.cmd[MBZ1_BIT])) |=> !cmd_flag)
        else $error("invalid command raised the flag");

    flag_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && !cmd_flag && !(dec_bus.match && r.cmd[IRQ_CMP_BIT])
         && !(dec_bus.zero_hit && r.cmd[IRQ_RST_BIT])) |=> !cmd_flag)
        else $error("flag rose with no enabled event");

    // ------------------------------------------------------------
    // Checks: output pins
    // ------------------------------------------------------------
    pin_other_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC) |=> ((pin_out ^ $past(pin_out)) & $past(pin_keep)) == '0)
        else $error("unselected pin moved");

    pin_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state != TCC_EXEC) |=> $stable(pin_out))
        else $error("pins moved outside a slot");

    pin_still_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC && !dec_bus.match && !(dec_bus.zero_hit && r.cmd[RST_ACT_BIT]))
        |=> $stable(pin_out))
        else $error("pin moved with no action due");

    // ------------------------------------------------------------
    // Checks: definition and step flags
    // ------------------------------------------------------------
    step_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state == TCC_EXEC)
        |=> step_mode == ($past(r.cmd[STEP_BIT]) && !$past(r.cmd[MBZ0_BIT]) && !$past(r.cmd[MBZ1_BIT])))
        else $error("step flag wrong");

    flags_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (r.state != TCC_EXEC) |=> ($stable(step_mode) && $stable(next_def)))
        else $error("command flags moved outside a slot");

    // ------------------------------------------------------------
    // Checks: register port
    // ------------------------------------------------------------
    // Read data must stand only in the cycle after the strobe.
    rdata_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !reg_rd |=> (reg_rdata == '0))
        else $error("read data outside its cycle");

    rdata_cmd_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_CMD) |=> (reg_rdata == $past(r.cmd)))
        else $error("command read back wrong");

    rdata_timer_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_TIMER) |=> (reg_rdata == 32'($past(r.timer))))
        else $error("timer read back wrong");

    rdata_stat_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_STATUS)
        |=> (reg_rdata == 32'({$past(step_mode), $past(next_def), $past(r.tzero), $past(cmd_flag)})))
        else $error("status read back wrong");

    rdata_pins_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_PINS) |=> (reg_rdata == 32'($past(pin_out))))
        else $error("pin read back wrong");

    rdata_void_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr > ADDR_PINS) |=> (reg_rdata == '0))
        else $error("unmapped read not zero");

    cmd_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == ADDR_CMD) |=> (r.cmd == $past(reg_wdata)))
        else $error("command word not stored whole");

    cmd_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(reg_wr && reg_addr == ADDR_CMD) |=> $stable(r.cmd))
        else $error("command word changed without a write");

    rst_clear_a: assert property (@(posedge mclk)
        sys_rst |=> (pin_out == '0 && !cmd_flag && !slot_done && !next_def && !step_mode && reg_rdata == '0))
        else $error("outputs not cleared by reset");

    match_c: cover property (@(posedge mclk) r.state == TCC_EXEC && dec_bus.match);
    zero_c:  cover property (@(posedge mclk) r.state == TCC_EXEC && dec_bus.zero_hit);
    clear_c: cover property (@(posedge mclk) cmd_flag && reg_wr && reg_addr == ADDR_STATUS);
    step_c:  cover property (@(posedge mclk) r.state == TCC_EXEC && dec_bus.step);
    bad_c:   cover property (@(posedge mclk) r.state == TCC_EXEC && !dec_bus.valid);

endmodule
